// >>> shared/dpram_pkg.sv
// Constants, types and register map of the dual-port synchronous memory.
// Operation
// - Two ports with separate inputs, outputs and clocks, working independently.
// - Array holds 18 Kbit with parity; every access is registered on an edge.
// - Widths 1, 2, 4 give depths 16384, 8192, 4096 without parity.
// - Widths 9, 18, 36 are 8/16/32 data plus 1/2/4 parity bits.
// - Address shrinks one bit per width doubling, fourteen down to nine bits.
// - Read address set before the edge; edge loads addressed word into output.
// - A read happens only with port enable set and write enable low.
// - Each port's active edge is configured as rising or falling.
// - Enable plus write enable on the edge stores data at the address.
// - A write updates the output register in transparent and read-before-write modes; no-change mode keeps it.
// - Transparent mode copies the written data into the output register.
// - Read-before-write mode loads the cell's previous contents into output.
package dpram_pkg;

  // Array geometry: 512 words of 32 data and 4 parity bits.
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int WORD_W = 36;
  localparam int DEPTH = 512;
  localparam int WORD_AW = 9;
  localparam int DSH_W = 5;
  localparam int PSH_W = 2;
  localparam int CNT_W = 16;

  // Register byte offsets on the bus.
  localparam logic [7:0] REG_CTRL_A = 8'h00;
  localparam logic [7:0] REG_CTRL_B = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // Control register field positions.
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_FALL_BIT = 8;

  // Values after reset.
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [WORD_W-1:0] OUT_RST = 36'h0_0000_0000;
  localparam logic [31:0] HRDATA_RST = 32'h0000_0000;

  // Port width selections.
  typedef enum logic [2:0] {
    WIDTH_1 = 3'b000,
    WIDTH_2 = 3'b001,
    WIDTH_4 = 3'b010,
    WIDTH_9 = 3'b011,
    WIDTH_18 = 3'b100,
    WIDTH_36 = 3'b101
  } width_e;

  // Output register behaviour during a write.
  typedef enum logic [1:0] {
    WRITE_FIRST = 2'b00,
    READ_FIRST = 2'b01,
    NO_CHANGE = 2'b10
  } wmode_e;

  // Pins of one memory port as they arrive from the fabric.
  typedef struct packed {
    logic clk;
    logic en;
    logic write_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [PAR_W-1:0] wpar;
  } port_in_s;

  // Configuration of one port.
  typedef struct packed {
    width_e width;
    wmode_e mode;
    logic fall_edge;
  } port_cfg_s;

  // Access held for the cycle in which the array answers.
  typedef struct packed {
    logic vld;
    logic wr;
    width_e width;
    wmode_e mode;
    logic [DSH_W-1:0] dsh;
    logic [PSH_W-1:0] psh;
    logic [DATA_W-1:0] wdata;
    logic [PAR_W-1:0] wpar;
  } stage_s;

  localparam port_cfg_s CFG_RST = '{width: WIDTH_36, mode: WRITE_FIRST,
                                    fall_edge: 1'b0};
  localparam stage_s STAGE_RST = '{vld: 1'b0, wr: 1'b0, width: WIDTH_36,
                                   mode: WRITE_FIRST, dsh: 5'h00, psh: 2'h0,
                                   wdata: 32'h0000_0000, wpar: 4'h0};

endpackage

// >>> hw/dpram_store.sv
// Storage array with two masked-write ports and registered read data.
module dpram_store #(
  parameter int DEPTH = dpram_pkg::DEPTH,
  parameter int WIDTH = dpram_pkg::WORD_W,
  parameter int AW = dpram_pkg::WORD_AW
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // First access port.
  input wire logic a_en,
  input wire logic [AW-1:0] a_word,
  input wire logic [WIDTH-1:0] a_wmask,
  input wire logic [WIDTH-1:0] a_wdata,
  output logic [WIDTH-1:0] a_rdata,
  // Second access port.
  input wire logic b_en,
  input wire logic [AW-1:0] b_word,
  input wire logic [WIDTH-1:0] b_wmask,
  input wire logic [WIDTH-1:0] b_wdata,
  output logic [WIDTH-1:0] b_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] a_merged;
  logic [WIDTH-1:0] b_base;
  logic [WIDTH-1:0] b_merged;

  // Merges masked bits; a shared word sees the first port's bits first.
  always_comb begin
    a_merged = (mem[a_word] & ~a_wmask) | (a_wdata & a_wmask);
    b_base = (a_en && (a_word == b_word)) ? a_merged : mem[b_word];
    b_merged = (b_base & ~b_wmask) | (b_wdata & b_wmask);
  end

  // The array has no reset; on a shared word the second port lands last.
  always_ff @(posedge hclk) begin
    if (a_en) begin
      mem[a_word] <= a_merged;
    end
    if (b_en) begin
      mem[b_word] <= b_merged;
    end
  end

  // Read data registers capture the word as it was before any write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else begin
      if (a_en) begin
        a_rdata <= mem[a_word];
      end
      if (b_en) begin
        b_rdata <= mem[b_word];
      end
    end
  end

endmodule

// >>> hw/dual_port_sync_ram.sv
// Dual-port synchronous memory with configuration over AHB-Lite.
module dual_port_sync_ram (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Memory port A.
  input wire logic port_a_clk,
  input wire logic port_a_en,
  input wire logic port_a_write_en,
  input wire logic [13:0] port_a_addr,
  input wire logic [31:0] port_a_write_data_in,
  input wire logic [3:0] port_a_write_par_in,
  output logic [31:0] port_a_read_data,
  output logic [3:0] port_a_read_par,
  // Memory port B.
  input wire logic port_b_clk,
  input wire logic port_b_en,
  input wire logic port_b_write_en,
  input wire logic [13:0] port_b_addr,
  input wire logic [31:0] port_b_write_data_in,
  input wire logic [3:0] port_b_write_par_in,
  output logic [31:0] port_b_read_data,
  output logic [3:0] port_b_read_par
);

  function automatic logic [31:0] dmask(input dpram_pkg::width_e w);
    case (w)
      dpram_pkg::WIDTH_1: dmask = 32'h0000_0001;
      dpram_pkg::WIDTH_2: dmask = 32'h0000_0003;
      dpram_pkg::WIDTH_4: dmask = 32'h0000_000F;
      dpram_pkg::WIDTH_9: dmask = 32'h0000_00FF;
      dpram_pkg::WIDTH_18: dmask = 32'h0000_FFFF;
      default: dmask = 32'hFFFF_FFFF;
    endcase
  endfunction

  // parity mask, none for narrow widths.
  function automatic logic [3:0] pmask(input dpram_pkg::width_e w);
    case (w)
      dpram_pkg::WIDTH_1, dpram_pkg::WIDTH_2, dpram_pkg::WIDTH_4: pmask = 4'h0;
      dpram_pkg::WIDTH_9: pmask = 4'h1;
      dpram_pkg::WIDTH_18: pmask = 4'h3;
      default: pmask = 4'hF;
    endcase
  endfunction

  // Picks one lane out of a stored word, parity above data.
  function automatic logic [35:0] lane_get(input logic [35:0] w,
                                           input logic [4:0] dsh,
                                           input logic [1:0] psh,
                                           input dpram_pkg::width_e wd);
    lane_get = {(w[35:32] >> psh) & pmask(wd),
                (w[31:0] >> dsh) & dmask(wd)};
  endfunction

  // Control register image of one port.
  function automatic logic [31:0] ctrl_word(input dpram_pkg::port_cfg_s c);
    ctrl_word = 32'h0000_0000;
    ctrl_word[dpram_pkg::CTRL_WIDTH_LSB +: 3] = c.width;
    ctrl_word[dpram_pkg::CTRL_MODE_LSB +: 2] = c.mode;
    ctrl_word[dpram_pkg::CTRL_FALL_BIT] = c.fall_edge;
  endfunction

  // Port configuration taken from a bus write.
  function automatic dpram_pkg::port_cfg_s cfg_from(input logic [31:0] d);
    return '{width: dpram_pkg::width_e'(d[dpram_pkg::CTRL_WIDTH_LSB +: 3]),
             mode: dpram_pkg::wmode_e'(d[dpram_pkg::CTRL_MODE_LSB +: 2]),
             fall_edge: d[dpram_pkg::CTRL_FALL_BIT]};
  endfunction

  // Bus state.
  dpram_pkg::port_cfg_s cfg_ff [2];
  dpram_pkg::port_cfg_s nxt_cfg [2];
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [7:0] wr_addr_ff;
  logic [7:0] nxt_wr_addr;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic hreadyout_ff;
  logic hresp_ff;
  logic take;

  // Port state, index 0 is port A and index 1 is port B.
  dpram_pkg::port_in_s pins [2];
  dpram_pkg::port_in_s sync1_ff [2];
  dpram_pkg::port_in_s sync2_ff [2];
  logic prev_clk_ff [2];
  logic act_edge [2];
  logic acc [2];
  dpram_pkg::stage_s stage_ff [2];
  dpram_pkg::stage_s nxt_stage [2];
  logic [35:0] out_ff [2];
  logic [35:0] nxt_out [2];
  logic [15:0] cnt_ff [2];
  logic [15:0] nxt_cnt [2];
  logic [35:0] old_lane [2];
  logic [35:0] wr_lane [2];
  logic [8:0] m_word [2];
  logic [4:0] a_dsh [2];
  logic [1:0] a_psh [2];
  logic [35:0] m_wmask [2];
  logic [35:0] m_wdata [2];
  logic [35:0] m_rdata [2];

  // Pins gathered per port.
  assign pins[0] = '{clk: port_a_clk, en: port_a_en,
                     write_en: port_a_write_en, addr: port_a_addr,
                     wdata: port_a_write_data_in, wpar: port_a_write_par_in};
  assign pins[1] = '{clk: port_b_clk, en: port_b_en,
                     write_en: port_b_write_en, addr: port_b_addr,
                     wdata: port_b_write_data_in, wpar: port_b_write_par_in};

  // Outputs straight from their registers.
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign port_a_read_data = out_ff[0][31:0];
  assign port_a_read_par = out_ff[0][35:32];
  assign port_b_read_data = out_ff[1][31:0];
  assign port_b_read_par = out_ff[1][35:32];

  // Address phase is taken when selected, ready and NONSEQ or SEQ.
  assign take = hsel & hready & htrans[1];

  // Bus decode: zero wait states, writes land in the data phase.
  always_comb begin
    nxt_cfg[0] = cfg_ff[0];
    nxt_cfg[1] = cfg_ff[1];
    nxt_wr_pend = take & hwrite;
    nxt_wr_addr = take ? haddr[7:0] : wr_addr_ff;
    if (wr_pend_ff) begin
      case (wr_addr_ff)
        dpram_pkg::REG_CTRL_A: nxt_cfg[0] = cfg_from(hwdata);
        dpram_pkg::REG_CTRL_B: nxt_cfg[1] = cfg_from(hwdata);
        default: nxt_cfg[0] = cfg_ff[0];
      endcase
    end
    // Reads see a write that is landing in the same cycle.
    nxt_hrdata = hrdata_ff;
    if (take && !hwrite) begin
      case (haddr[7:0])
        dpram_pkg::REG_CTRL_A: nxt_hrdata = ctrl_word(nxt_cfg[0]);
        dpram_pkg::REG_CTRL_B: nxt_hrdata = ctrl_word(nxt_cfg[1]);
        dpram_pkg::REG_STATUS: nxt_hrdata = {cnt_ff[1], cnt_ff[0]};
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff[0] <= dpram_pkg::CFG_RST;
      cfg_ff[1] <= dpram_pkg::CFG_RST;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= dpram_pkg::HRDATA_RST;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_port

    // configured edge of the synchronised port clock.
    assign act_edge[i] = cfg_ff[i].fall_edge ?
                         (prev_clk_ff[i] & ~sync2_ff[i].clk) :
                         (~prev_clk_ff[i] & sync2_ff[i].clk);
    // nothing happens unless the port is enabled.
    assign acc[i] = act_edge[i] & sync2_ff[i].en;

    // Lane views of the answered access.
    assign old_lane[i] = lane_get(m_rdata[i], stage_ff[i].dsh,
                                  stage_ff[i].psh, stage_ff[i].width);
    assign wr_lane[i] = {stage_ff[i].wpar & pmask(stage_ff[i].width),
                         stage_ff[i].wdata & dmask(stage_ff[i].width)};

    // split address into word and lane by width.
    always_comb begin
      a_dsh[i] = 5'h00;
      a_psh[i] = 2'h0;
      case (cfg_ff[i].width)
        dpram_pkg::WIDTH_1: begin
          m_word[i] = sync2_ff[i].addr[13:5];
          a_dsh[i] = sync2_ff[i].addr[4:0];
        end
        dpram_pkg::WIDTH_2: begin
          m_word[i] = sync2_ff[i].addr[12:4];
          a_dsh[i] = {sync2_ff[i].addr[3:0], 1'b0};
        end
        dpram_pkg::WIDTH_4: begin
          m_word[i] = sync2_ff[i].addr[11:3];
          a_dsh[i] = {sync2_ff[i].addr[2:0], 2'b00};
        end
        dpram_pkg::WIDTH_9: begin
          m_word[i] = sync2_ff[i].addr[10:2];
          a_dsh[i] = {sync2_ff[i].addr[1:0], 3'b000};
          a_psh[i] = sync2_ff[i].addr[1:0];
        end
        dpram_pkg::WIDTH_18: begin
          m_word[i] = sync2_ff[i].addr[9:1];
          a_dsh[i] = {sync2_ff[i].addr[0], 4'h0};
          a_psh[i] = {sync2_ff[i].addr[0], 1'b0};
        end
        default: begin
          m_word[i] = sync2_ff[i].addr[8:0];
        end
      endcase
    end

    // Array request, held access, output register and access count.
    always_comb begin
      // masked write of the lane on an enabled write edge.
      m_wmask[i] = 36'h0_0000_0000;
      if (acc[i] && sync2_ff[i].write_en) begin
        m_wmask[i] = {pmask(cfg_ff[i].width) << a_psh[i],
                      dmask(cfg_ff[i].width) << a_dsh[i]};
      end
      m_wdata[i] = {sync2_ff[i].wpar << a_psh[i],
                    sync2_ff[i].wdata << a_dsh[i]};
      nxt_stage[i] = '{vld: acc[i], wr: acc[i] & sync2_ff[i].write_en,
                       width: cfg_ff[i].width, mode: cfg_ff[i].mode,
                       dsh: a_dsh[i], psh: a_psh[i],
                       wdata: sync2_ff[i].wdata, wpar: sync2_ff[i].wpar};
      nxt_cnt[i] = acc[i] ? cnt_ff[i] + 16'h0001 : cnt_ff[i];
      nxt_out[i] = out_ff[i];
      if (stage_ff[i].vld) begin
        if (!stage_ff[i].wr) begin
          // a read loads the addressed word.
          nxt_out[i] = old_lane[i];
        end else begin
          case (stage_ff[i].mode)
            dpram_pkg::WRITE_FIRST: nxt_out[i] = wr_lane[i];
            dpram_pkg::READ_FIRST: nxt_out[i] = old_lane[i];
            default: nxt_out[i] = out_ff[i];
          endcase
        end
      end
    end

    // Pins pass two flip-flops before any logic reads them.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync1_ff[i] <= '0;
        sync2_ff[i] <= '0;
        prev_clk_ff[i] <= 1'b0;
        stage_ff[i] <= dpram_pkg::STAGE_RST;
        out_ff[i] <= dpram_pkg::OUT_RST;
        cnt_ff[i] <= dpram_pkg::CNT_RST;
      end else begin
        sync1_ff[i] <= pins[i];
        sync2_ff[i] <= sync1_ff[i];
        prev_clk_ff[i] <= sync2_ff[i].clk;
        stage_ff[i] <= nxt_stage[i];
        out_ff[i] <= nxt_out[i];
        cnt_ff[i] <= nxt_cnt[i];
      end
    end

    // Enabled write edge followed by its answer cycle.
    sequence s_wr_issue;
      acc[i] && sync2_ff[i].write_en ##1 stage_ff[i].vld && stage_ff[i].wr;
    endsequence

    // Enabled read edge followed by its answer cycle.
    sequence s_rd_issue;
      acc[i] && !sync2_ff[i].write_en ##1 stage_ff[i].vld && !stage_ff[i].wr;
    endsequence

    a_out_quiet: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !stage_ff[i].vld |=> $stable(out_ff[i]))
      else $error("output moved without an access");

    a_edge_registered: assert property (
      @(posedge hclk) disable iff (!hresetn)
      acc[i] |=> stage_ff[i].vld &&
                 stage_ff[i].wr == $past(sync2_ff[i].write_en))
      else $error("access not registered");

    a_narrow_no_par: assert property (
      @(posedge hclk) disable iff (!hresetn)
      stage_ff[i].vld && !stage_ff[i].wr &&
      stage_ff[i].width inside {dpram_pkg::WIDTH_1, dpram_pkg::WIDTH_2,
                                dpram_pkg::WIDTH_4}
      |=> out_ff[i][35:32] == 4'h0)
      else $error("narrow width produced parity");

    a_wide_full_word: assert property (
      @(posedge hclk) disable iff (!hresetn)
      stage_ff[i].vld && !stage_ff[i].wr &&
      stage_ff[i].width == dpram_pkg::WIDTH_36
      |=> out_ff[i] == $past(m_rdata[i]))
      else $error("36-bit read not the whole word");

    a_addr_split: assert property (
      @(posedge hclk) disable iff (!hresetn)
      acc[i] && cfg_ff[i].width == dpram_pkg::WIDTH_1
      |-> m_word[i] == sync2_ff[i].addr[13:5])
      else $error("1-bit word index wrong");

    a_read_loads: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_rd_issue |=> out_ff[i] == $past(old_lane[i]))
      else $error("read did not load output");

    a_enable_gates: assert property (
      @(posedge hclk) disable iff (!hresetn)
      act_edge[i] && !sync2_ff[i].en |=> !stage_ff[i].vld)
      else $error("access without enable");

    a_edge_polarity: assert property (
      @(posedge hclk) disable iff (!hresetn)
      acc[i] |-> sync2_ff[i].clk == !cfg_ff[i].fall_edge &&
                 prev_clk_ff[i] == cfg_ff[i].fall_edge)
      else $error("access on wrong clock edge");

    a_write_mask: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc[i] && sync2_ff[i].write_en) == (m_wmask[i] != 36'h0_0000_0000))
      else $error("write mask disagrees with write edge");

    a_write_updates: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_wr_issue ##0 stage_ff[i].mode inside {dpram_pkg::WRITE_FIRST,
                                              dpram_pkg::READ_FIRST}
      |=> out_ff[i] == ($past(stage_ff[i].mode) == dpram_pkg::WRITE_FIRST ?
                        $past(wr_lane[i]) : $past(old_lane[i])))
      else $error("write did not update output");

    a_transparent_out: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_wr_issue ##0 stage_ff[i].mode == dpram_pkg::WRITE_FIRST
      |=> out_ff[i] == $past(wr_lane[i]))
      else $error("transparent write not shown");

    a_read_first_out: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_wr_issue ##0 stage_ff[i].mode == dpram_pkg::READ_FIRST
      |=> out_ff[i] == $past(old_lane[i]))
      else $error("old contents not shown");

    a_keep_out: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_wr_issue ##0 stage_ff[i].mode == dpram_pkg::NO_CHANGE
      |=> $stable(out_ff[i]))
      else $error("keep mode changed output");
  end

  // one shared 512 x 36 array behind both ports.
  dpram_store #(
    .DEPTH(dpram_pkg::DEPTH),
    .WIDTH(dpram_pkg::WORD_W),
    .AW(dpram_pkg::WORD_AW)
  ) u_store (
    .hclk(hclk),
    .hresetn(hresetn),
    .a_en(acc[0]),
    .a_word(m_word[0]),
    .a_wmask(m_wmask[0]),
    .a_wdata(m_wdata[0]),
    .a_rdata(m_rdata[0]),
    .b_en(acc[1]),
    .b_word(m_word[1]),
    .b_wmask(m_wmask[1]),
    .b_wdata(m_wdata[1]),
    .b_rdata(m_rdata[1])
  );

endmodule

// >>> dv/fabric_port.sv
// Fabric-side model that drives one memory port with slow, framed clock pulses.
module fabric_port (
  // Bench clock.
  input wire logic hclk,
  // Memory port pins.
  output logic clk,
  output logic en,
  output logic we,
  output logic [13:0] addr,
  output logic [31:0] wdata,
  output logic [3:0] wpar
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins idle with the port clock standing still low.
  initial begin
    clk = 1'b0;
    en = 1'b0;
    we = 1'b0;
    addr = 14'h0000;
    wdata = 32'h0000_0000;
    wpar = 4'h0;
  end

  // One clock pulse; with rise_only the enable covers only the rising edge.
  task automatic access(input logic wr, input logic [13:0] a,
                        input logic [35:0] d, input logic rise_only);
    @(posedge hclk);
    // controls set well before the edge.
    en <= 1'b1;
    we <= wr;
    addr <= a;
    wdata <= d[31:0];
    wpar <= d[35:32];
    repeat (6) @(posedge hclk);
    clk <= 1'b1;
    repeat (6) @(posedge hclk);
    if (rise_only) begin
      en <= 1'b0;
    end
    repeat (6) @(posedge hclk);
    clk <= 1'b0;
    repeat (6) @(posedge hclk);
    // Enable drops; the other released pins show the inverse of their last value.
    en <= 1'b0;
    we <= ~wr;
    addr <= ~a;
    wdata <= ~d[31:0];
    wpar <= ~d[35:32];
    repeat (6) @(posedge hclk);
  endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the dual-port memory and its control registers.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic a_clk, a_en, a_we, b_clk, b_en, b_we;
  logic [13:0] a_addr, b_addr;
  logic [31:0] a_wd, b_wd, a_rd, b_rd;
  logic [3:0] a_wp, b_wp, a_rp, b_rp;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [35:0] W = 36'hB_A5C3_96F1;

  // Design, with its bus ready looped back.
  dual_port_sync_ram dual_port_sync_ram_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .port_a_clk(a_clk), .port_a_en(a_en),
    .port_a_write_en(a_we), .port_a_addr(a_addr),
    .port_a_write_data_in(a_wd), .port_a_write_par_in(a_wp),
    .port_a_read_data(a_rd), .port_a_read_par(a_rp),
    .port_b_clk(b_clk), .port_b_en(b_en), .port_b_write_en(b_we),
    .port_b_addr(b_addr), .port_b_write_data_in(b_wd),
    .port_b_write_par_in(b_wp), .port_b_read_data(b_rd),
    .port_b_read_par(b_rp));

  // Fabric models for both ports.
  fabric_port pa_i (.hclk(hclk), .clk(a_clk), .en(a_en), .we(a_we),
                    .addr(a_addr), .wdata(a_wd), .wpar(a_wp));
  fabric_port pb_i (.hclk(hclk), .clk(b_clk), .en(b_en), .we(b_we),
                    .addr(b_addr), .wdata(b_wd), .wpar(b_wp));

  // Bus clock at 20 MHz.
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Prints the verdict and ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end

  // Compares a seen value with the expected one.
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One AHB-Lite single transfer; read data taken at the data phase end.
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  // Expected lane of a stored word for width index i and lane s.
  function automatic logic [35:0] lane(input logic [35:0] w, input int i,
                                       input int s);
    int dw;
    int pw;
    logic [31:0] d;
    logic [3:0] p;
    dw = (i < 3) ? (1 << i) : (8 << (i - 3));
    pw = (i < 3) ? 0 : (1 << (i - 3));
    d = w[31:0] >> (s * dw);
    p = w[35:32] >> (s * pw);
    if (dw < 32) d = d & ((32'h1 << dw) - 32'h1);
    p = p & ((4'h1 << pw) - 4'h1);
    return {p, d};
  endfunction

  // Main sequence.
  initial begin
    logic [31:0] q;
    int sh;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b0, dpram_pkg::REG_CTRL_A, 32'h0, q);
    check({4'h0, q}, 36'h0_0000_0005);
    ahb(1'b0, 8'h0C, 32'h0, q);
    check({4'h0, q}, 36'h0);
    check({35'h0, hresp}, 36'h0);
    $display("test reset done");
    // Write modes on port A, full width.
    pa_i.access(1'b1, 14'h0005, W, 1'b0);
    pa_i.access(1'b1, 14'h0007, 36'h3_0F0F_1234, 1'b0);
    check({a_rp, a_rd}, 36'h3_0F0F_1234);
    ahb(1'b1, dpram_pkg::REG_CTRL_A, 32'h0000_0015, q);
    pa_i.access(1'b1, 14'h0007, 36'hC_F0F0_5678, 1'b0);
    check({a_rp, a_rd}, 36'h3_0F0F_1234);
    ahb(1'b1, dpram_pkg::REG_CTRL_A, 32'h0000_0025, q);
    pa_i.access(1'b1, 14'h0007, 36'h5_DEAD_0001, 1'b0);
    check({a_rp, a_rd}, 36'h3_0F0F_1234);
    pa_i.access(1'b0, 14'h0007, 36'h0, 1'b0);
    check({a_rp, a_rd}, 36'h5_DEAD_0001);
    $display("test write modes done");
    // Every width on port B, last lane of word 5.
    for (int i = 0; i < 6; i++) begin
      sh = 5 - i;
      ahb(1'b1, dpram_pkg::REG_CTRL_B, 32'(i), q);
      pb_i.access(1'b0, 14'((5 << sh) | ((1 << sh) - 1)), 36'h0, 1'b0);
      check({b_rp, b_rd}, lane(W, i, (1 << sh) - 1));
    end
    $display("test widths done");
    // Byte write with parity on B, seen whole on A.
    ahb(1'b1, dpram_pkg::REG_CTRL_B, 32'h0000_0003, q);
    pb_i.access(1'b1, 14'h0016, 36'h1_0000_003C, 1'b0);
    pa_i.access(1'b0, 14'h0005, 36'h0, 1'b0);
    check({a_rp, a_rd}, 36'hF_A53C_96F1);
    $display("test cross port done");
    // Falling edge active: enable over the rising edge only does nothing.
    ahb(1'b1, dpram_pkg::REG_CTRL_A, 32'h0000_0105, q);
    pa_i.access(1'b0, 14'h0007, 36'h0, 1'b1);
    check({a_rp, a_rd}, 36'hF_A53C_96F1);
    pa_i.access(1'b0, 14'h0007, 36'h0, 1'b0);
    check({a_rp, a_rd}, 36'h5_DEAD_0001);
    ahb(1'b0, dpram_pkg::REG_STATUS, 32'h0, q);
    check({4'h0, q}, 36'h0_0007_0007);
    $display("test clock edge done");
    // Spare codes: width 6 acts as a full word, mode 3 as keep.
    ahb(1'b1, dpram_pkg::REG_CTRL_B, 32'h0000_0036, q);
    pb_i.access(1'b1, 14'h0005, 36'h6_1357_9BDF, 1'b0);
    check({b_rp, b_rd}, 36'h1_0000_003C);
    pb_i.access(1'b0, 14'h0005, 36'h0, 1'b0);
    check({b_rp, b_rd}, 36'h6_1357_9BDF);
    $display("test spare codes done");
    test_done();
  end
endmodule
